// [verilog/cadc_params.svh]
/*
 Shared constants of the current converter control pair: counts, offsets, bits.
 Assumes a 100 MHz sys_clk on both ends.
*/
`ifndef CADC_PARAMS_SVH
`define CADC_PARAMS_SVH
`define CADC_NCH 8
`define CADC_DW 20
`define CADC_CLK_MHZ 100
// Internal clock periods: 1470, 1380, 1379 and 2901.
`define CADC_T6 12'h5BE
`define CADC_T7 12'h564
`define CADC_T8 12'h563
`define CADC_T10 12'hB55
`define CADC_DIV_LAST 2'h3
`define CADC_PKT_PC 11
// Code for one packet; the scale is arbitrary.
`define CADC_PKT_CODE 20'h0B000
`define CADC_RST_US 50
`define CADC_RST_CYC (`CADC_RST_US * `CADC_CLK_MHZ)
`define CADC_TST_HI_NS 1000
`define CADC_TST_HI_CYC ((`CADC_TST_HI_NS * `CADC_CLK_MHZ + 999) / 1000)
`define CADC_TST_LO_CYC 100
`define CADC_RST_DISCARD 3'h4
`define CADC_TEST_DISCARD 3'h4
`define CADC_SCLK_HALF 8
`define CADC_GUARD 24'h000020
`define CADC_OFS_CTRL 12'h000
`define CADC_OFS_INTEGRATION_PERIOD 12'h004
`define CADC_OFS_PKTS 12'h008
`define CADC_OFS_STAT 12'h00C
`define CADC_IDX_DATA0 10'h004
`define CADC_CTRL_RUN 0
`define CADC_CTRL_TEST 1
`define CADC_CTRL_DIV 2
`define CADC_CTRL_SPD 3
`define CADC_CTRL_RST 4
`define CADC_STAT_NEW 0
`define CADC_CTRL_RV 4'h0
`define CADC_INTEGRATION_PERIOD_RV 24'h009C40
`define CADC_PKTS_RV 8'h00
`endif

// [verilog/cadc_pkg.sv]
/*
 Types of the current converter control pair.
 Assumes nothing of its surroundings.
*/
package cadc_pkg;
   typedef enum logic [1:0] {
      CADC_IDLE = 2'b01,
      CADC_MEAS = 2'b10
   } cadc_meas_t;
   typedef enum logic [2:0] {
      CADC_SH_IDLE = 3'b001,
      CADC_SH_LOW = 3'b010,
      CADC_SH_HIGH = 3'b100
   } cadc_shift_t;
endpackage

// [verilog/cadc_if.sv]
/*
 Pins between the converter and its host controller.
 Assumes the testbench joins both modports; every pin is one-way.
*/
`timescale 1ns/1ps
interface cadc_if;
   logic integrate_toggle;
   logic zero_input_strobe;
   logic shift_clock;
   logic chain_in;
   logic chain_out;
   logic result_ready_n;
   logic reset_n;
   logic sysclk_div_sel;
   logic speed_power_sel;
   modport dev (
      input integrate_toggle,
      input zero_input_strobe,
      input shift_clock,
      input chain_in,
      input reset_n,
      input sysclk_div_sel,
      input speed_power_sel,
      output chain_out,
      output result_ready_n
   );
   modport host (
      output integrate_toggle,
      output zero_input_strobe,
      output shift_clock,
      output chain_in,
      output reset_n,
      output sysclk_div_sel,
      output speed_power_sel,
      input chain_out,
      input result_ready_n
   );
endinterface

// [verilog/cadc_device.sv]
/*
 Converter end: integration timing, test mode, data-ready and serial readout.
 Assumes all link pins are asynchronous to sys_clk and lane samples are
 stable digital stand-ins for the eight analog inputs.
*/
// Behaviour
// - strobe high at toggle change enters test
// - test mode disconnects inputs, zero result
// - each strobe rise adds one packet
// - host strobe high phase at least 1us
// - test mode in both operation modes
// - host leaves test, discards early results
// - eight lanes, readout independent of conversion
// - chain input shifts through to output
// - host holds shift clock low idle
// - divider select divides clock by four
// - speed select picks mode, host limits
// - ready low when new result loaded
// - ready timed from free internal divider
// - host polls ready, not toggle timing
// - reset asynchronous, host pulse 50us
// - host discards first four results
// - host toggles in step with clock
// - each cycle measures and resets side
// - busy at toggle gives non-continuous operation
// - toggle rise starts A, fall passes A
// - ready stays low until clock high-low
// - continuous ready 1380 periods after toggle
`timescale 1ns/1ps
`include "cadc_params.svh"
module cadc_device
   import cadc_pkg::*;
#(
   parameter int NCH = `CADC_NCH,
   parameter int DW = `CADC_DW,
   parameter logic [DW-1:0] PKT_CODE = `CADC_PKT_CODE
) (
   input wire logic sys_clk,
   cadc_if.dev link,
   input wire logic [NCH*DW-1:0] lane_sample,
   output logic test_active,
   output logic cont_mode,
   output logic hi_speed
);
   localparam int NB = NCH * DW;
   localparam int NP = 6;

   logic rst_n;
   logic [NP-1:0] pin_raw;
   logic [NP-1:0] s1_q;
   logic [NP-1:0] s2_q;
   logic [NP-1:0] s3_q;
   logic tog_chg;
   logic stb_s;
   logic stb_rise;
   logic sck_rise;
   logic sck_fall;
   logic chain_s;
   logic div_s;
   logic [1:0] div_q;
   logic tick;
   logic test_q;
   logic side_a_q;
   logic [7:0] pkt_q;
   logic [DW+7:0] pkt_prod;
   logic [DW-1:0] pkt_val;
   logic [NB-1:0] period_val;
   cadc_meas_t mst_q;
   logic [11:0] mcnt_q;
   logic [11:0] rdy_at_q;
   logic [11:0] end_at_q;
   logic ncont_q;
   logic pend_q;
   logic start_c;
   logic start_n;
   logic rdy_hit;
   logic [NB-1:0] pend_val_q;
   logic [NB-1:0] held_q;
   logic [NB-1:0] sh_q;
   logic ready_n_q;
   logic seen_q;
   logic [2:0] arm_q;

   // The pin acts straight on every flop, so reset needs no running clock.
   assign rst_n = link.reset_n;

   assign pin_raw = {link.speed_power_sel, link.sysclk_div_sel, link.chain_in,
                     link.shift_clock, link.zero_input_strobe, link.integrate_toggle};

   genvar gi;
   generate
      for (gi = 0; gi < NP; gi++) begin : g_sync
         always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               s1_q[gi] <= 1'b0;
               s2_q[gi] <= 1'b0;
               s3_q[gi] <= 1'b0;
            end else begin
               s1_q[gi] <= pin_raw[gi];
               s2_q[gi] <= s1_q[gi];
               s3_q[gi] <= s2_q[gi];
            end
         end
      end
   endgenerate

   // Edges are ignored until all stages hold real pin levels; a toggle or
   // shift clock left high across a reset would otherwise fake an edge.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         arm_q <= 3'h0;
      end else begin
         arm_q <= {arm_q[1:0], 1'b1};
      end
   end

   assign tog_chg = arm_q[2] & (s2_q[0] ^ s3_q[0]);
   assign stb_s = s2_q[1];
   assign stb_rise = arm_q[2] & s2_q[1] & ~s3_q[1];
   assign sck_rise = arm_q[2] & s2_q[2] & ~s3_q[2];
   assign sck_fall = arm_q[2] & ~s2_q[2] & s3_q[2];
   assign chain_s = s2_q[3];
   assign div_s = s2_q[4];

   // The divider runs free from reset, so its phase against the toggle is
   // arbitrary and ready can move by up to three system clock periods.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_q <= 2'h0;
      end else if (div_s) begin
         div_q <= div_q + 2'h1;
      end else begin
         div_q <= 2'h0;
      end
   end

   assign tick = !div_s || (div_q == `CADC_DIV_LAST);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         test_q <= 1'b0;
         side_a_q <= 1'b0;
         pkt_q <= 8'h00;
      end else if (tog_chg) begin
         test_q <= stb_s;
         side_a_q <= s2_q[0];
         pkt_q <= 8'h00;
      end else if (test_q && stb_rise && pkt_q != 8'hFF) begin
         pkt_q <= pkt_q + 8'h01;
      end
   end

   // Packet charge depends only on the count of rises, never on the period.
   assign pkt_prod = {8'h00, PKT_CODE} * {{DW{1'b0}}, pkt_q};
   assign pkt_val = (|pkt_prod[DW+7:DW]) ? {DW{1'b1}} : pkt_prod[DW-1:0];

   generate
      for (gi = 0; gi < NCH; gi++) begin : g_lane
         // With the inputs cut off only injected packets reach the result.
         assign period_val[gi*DW +: DW] = test_q ? pkt_val
                                                 : lane_sample[gi*DW +: DW];
      end
   endgenerate

   assign start_c = (mst_q == CADC_IDLE) && !pend_q && tog_chg;
   assign start_n = (mst_q == CADC_IDLE) && pend_q;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mst_q <= CADC_IDLE;
         mcnt_q <= 12'h000;
         rdy_at_q <= `CADC_T7;
         end_at_q <= `CADC_T6;
         ncont_q <= 1'b1;
      end else begin
         case (mst_q)
            CADC_IDLE: begin
               mcnt_q <= 12'h000;
               if (start_n) begin
                  mst_q <= CADC_MEAS;
                  rdy_at_q <= `CADC_T8;
                  end_at_q <= `CADC_T10;
                  ncont_q <= 1'b1;
               end else if (start_c) begin
                  mst_q <= CADC_MEAS;
                  rdy_at_q <= `CADC_T7;
                  end_at_q <= `CADC_T6;
                  ncont_q <= 1'b0;
               end
            end
            CADC_MEAS: begin
               if (tick) begin
                  mcnt_q <= mcnt_q + 12'h001;
                  if (mcnt_q == end_at_q - 12'h001) begin
                     mst_q <= CADC_IDLE;
                  end
               end
            end
            default: begin
               mst_q <= CADC_IDLE;
            end
         endcase
      end
   end

   // A toggle during a busy measurement is held back until the digitizer
   // catches up; a third period in that gap overwrites the held one.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_q <= 1'b0;
         pend_val_q <= '0;
      end else if (tog_chg && !start_c) begin
         pend_q <= 1'b1;
         pend_val_q <= period_val;
      end else if (start_n) begin
         pend_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         held_q <= '0;
      end else if (start_c) begin
         held_q <= period_val;
      end else if (start_n) begin
         held_q <= pend_val_q;
      end
   end

   assign rdy_hit = (mst_q == CADC_MEAS) && tick && (mcnt_q == rdy_at_q - 12'h001);

   // Readout runs on the shift clock alone, apart from the measurement.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sh_q <= '0;
         ready_n_q <= 1'b1;
         seen_q <= 1'b0;
      end else if (rdy_hit) begin
         sh_q <= held_q;
         ready_n_q <= 1'b0;
         seen_q <= 1'b0;
      end else if (sck_rise) begin
         sh_q <= {sh_q[NB-2:0], chain_s};
         seen_q <= !ready_n_q;
      end else if (sck_fall && seen_q) begin
         ready_n_q <= 1'b1;
         seen_q <= 1'b0;
      end
   end

   assign link.result_ready_n = ready_n_q;
   assign link.chain_out = sh_q[NB-1];
   assign test_active = test_q;
   assign cont_mode = !ncont_q;
   // Speed only sets the analog bias; its clock limit is the host's to keep.
   assign hi_speed = s2_q[5];
endmodule

// [verilog/cadc_host.sv]
/*
 Host controller end: APB registers, reset pulse, integration toggle,
 test strobe and serial readout of the converter.
 Assumes an APB master on sys_clk and a converter on the far link pins.
*/
`timescale 1ns/1ps
`include "cadc_params.svh"
module cadc_host
   import cadc_pkg::*;
#(
   parameter int NCH = `CADC_NCH,
   parameter int DW = `CADC_DW,
   parameter int NDEV = 1,
   parameter int RST_CYC = `CADC_RST_CYC,
   parameter int TST_HI = `CADC_TST_HI_CYC,
   parameter int TST_LO = `CADC_TST_LO_CYC,
   parameter int SCLK_HALF = `CADC_SCLK_HALF
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   cadc_if.host link
);
   localparam int NB = NCH * DW;
   localparam int TOT = NDEV * NB;
   localparam int RW = $clog2(RST_CYC + 1);
   localparam int CW = $clog2(TOT + 1);
   localparam int IW = $clog2(NCH);

   logic wr;
   logic [9:0] didx;
   logic [31:0] rd_d;
   logic err_d;
   logic [3:0] ctrl_q;
   logic [23:0] integration_period_q;
   logic [7:0] pkts_q;
   logic new_q;
   logic [DW-1:0] data_q [NCH];
   logic rst_go;
   logic [RW-1:0] rcnt_q;
   logic rstn_q;
   logic [2:0] disc_q;
   logic running;
   logic [23:0] tcnt_q;
   logic [23:0] left;
   logic tog_q;
   logic tog_evt;
   logic stb_q;
   logic [7:0] pleft_q;
   logic [15:0] pcnt_q;
   logic [1:0] rs1_q;
   logic [1:0] rs2_q;
   cadc_shift_t sst_q;
   logic [15:0] hcnt_q;
   logic [CW-1:0] bit_q;
   logic [NB-1:0] sr_q;
   logic sck_q;
   logic guard_ok;
   logic cap;

   assign wr = psel && penable && pwrite;
   assign pready = psel && penable;
   assign didx = paddr[11:2] - `CADC_IDX_DATA0;
   assign rst_go = wr && paddr == `CADC_OFS_CTRL && pwdata[`CADC_CTRL_RST];

   always_comb begin
      rd_d = 32'h0;
      err_d = 1'b0;
      case (paddr)
         `CADC_OFS_CTRL: rd_d = {28'h0, ctrl_q};
         `CADC_OFS_INTEGRATION_PERIOD: rd_d = {8'h0, integration_period_q};
         `CADC_OFS_PKTS: rd_d = {24'h0, pkts_q};
         `CADC_OFS_STAT: rd_d = {28'h0, sst_q != CADC_SH_IDLE, disc_q != 3'h0, !rstn_q, new_q};
         default: begin
            if (paddr[1:0] == 2'h0 && paddr[11:2] >= `CADC_IDX_DATA0
                && didx < 10'(NCH) && !pwrite) begin
               rd_d = {{(32 - DW){1'b0}}, data_q[didx[IW-1:0]]};
            end else begin
               err_d = 1'b1;
            end
         end
      endcase
   end

   // Answer is prepared in the setup cycle so the access phase ends at once.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         prdata <= pwrite ? 32'h0 : rd_d;
         pslverr <= err_d;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ctrl_q <= `CADC_CTRL_RV;
         integration_period_q <= `CADC_INTEGRATION_PERIOD_RV;
         pkts_q <= `CADC_PKTS_RV;
      end else if (wr && paddr == `CADC_OFS_CTRL) begin
         ctrl_q <= pwdata[3:0];
      end else if (wr && paddr == `CADC_OFS_INTEGRATION_PERIOD) begin
         integration_period_q <= pwdata[23:0];
      end else if (wr && paddr == `CADC_OFS_PKTS) begin
         pkts_q <= pwdata[7:0];
      end
   end

   // The pulse is a plain counter, so it cannot glitch shorter than RST_CYC.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rcnt_q <= RW'(RST_CYC);
         rstn_q <= 1'b0;
      end else begin
         rstn_q <= (rcnt_q == '0) && !rst_go;
         if (rst_go) begin
            rcnt_q <= RW'(RST_CYC);
         end else if (rcnt_q != '0) begin
            rcnt_q <= rcnt_q - RW'(1);
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n || !rstn_q) begin
         disc_q <= `CADC_RST_DISCARD;
      end else if (wr && paddr == `CADC_OFS_CTRL && ctrl_q[`CADC_CTRL_TEST]
                   && !pwdata[`CADC_CTRL_TEST]) begin
         disc_q <= `CADC_TEST_DISCARD;
      end else if (cap && disc_q != 3'h0) begin
         disc_q <= disc_q - 3'h1;
      end
   end

   assign running = ctrl_q[`CADC_CTRL_RUN] && rstn_q;
   assign tog_evt = running && (tcnt_q + 24'h1 >= integration_period_q);
   assign left = integration_period_q - tcnt_q;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         tcnt_q <= 24'h0;
         tog_q <= 1'b0;
      end else if (!running) begin
         tcnt_q <= 24'h0;
      end else if (tog_evt) begin
         tcnt_q <= 24'h0;
         tog_q <= !tog_q;
      end else begin
         tcnt_q <= tcnt_q + 24'h1;
      end
   end

   // Packets are only started if low and high phases end before the toggle.
   always_ff @(posedge sys_clk) begin
      if (!rst_n || !ctrl_q[`CADC_CTRL_TEST]) begin
         stb_q <= 1'b0;
         pleft_q <= 8'h0;
         pcnt_q <= 16'h0;
      end else if (tog_evt) begin
         stb_q <= 1'b1;
         pleft_q <= pkts_q;
         pcnt_q <= 16'(TST_HI);
      end else if (pcnt_q != 16'h0) begin
         pcnt_q <= pcnt_q - 16'h1;
      end else if (!stb_q) begin
         stb_q <= 1'b1;
         pcnt_q <= 16'(TST_HI);
      end else if (pleft_q != 8'h0 && left > 24'(TST_LO + TST_HI) + `CADC_GUARD) begin
         stb_q <= 1'b0;
         pleft_q <= pleft_q - 8'h1;
         pcnt_q <= 16'(TST_LO);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rs1_q <= 2'h3;
         rs2_q <= 2'h3;
      end else begin
         rs1_q <= {link.result_ready_n, link.chain_out};
         rs2_q <= rs1_q;
      end
   end

   assign guard_ok = !(running && left <= `CADC_GUARD);
   assign cap = (sst_q == CADC_SH_LOW) && hcnt_q == 16'h0 && guard_ok
                && bit_q == CW'(NB);

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         sst_q <= CADC_SH_IDLE;
         hcnt_q <= 16'h0;
         bit_q <= '0;
         sr_q <= '0;
         sck_q <= 1'b0;
      end else begin
         case (sst_q)
            CADC_SH_IDLE: begin
               sck_q <= 1'b0;
               bit_q <= '0;
               hcnt_q <= 16'(SCLK_HALF);
               if (!rs2_q[1] && rstn_q) begin
                  sst_q <= CADC_SH_LOW;
               end
            end
            CADC_SH_LOW: begin
               if (hcnt_q != 16'h0) begin
                  hcnt_q <= hcnt_q - 16'h1;
               end else if (guard_ok) begin
                  if (bit_q == CW'(TOT)) begin
                     sst_q <= CADC_SH_IDLE;
                  end else begin
                     if (bit_q < CW'(NB)) begin
                        sr_q <= {sr_q[NB-2:0], rs2_q[0]};
                     end
                     sck_q <= 1'b1;
                     hcnt_q <= 16'(SCLK_HALF);
                     sst_q <= CADC_SH_HIGH;
                  end
               end
            end
            CADC_SH_HIGH: begin
               // The fall is never held back, so the clock cannot stay high
               // across a toggle; only rises wait for the guard window.
               if (hcnt_q != 16'h0) begin
                  hcnt_q <= hcnt_q - 16'h1;
               end else begin
                  sck_q <= 1'b0;
                  bit_q <= bit_q + CW'(1);
                  hcnt_q <= 16'(SCLK_HALF);
                  sst_q <= CADC_SH_LOW;
               end
            end
            default: begin
               sst_q <= CADC_SH_IDLE;
            end
         endcase
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < NCH; gi++) begin : g_data
         always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
               data_q[gi] <= '0;
            end else if (cap && disc_q == 3'h0) begin
               data_q[gi] <= sr_q[gi*DW +: DW];
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         new_q <= 1'b0;
      end else if (cap && disc_q == 3'h0) begin
         new_q <= 1'b1;
      end else if (wr && paddr == `CADC_OFS_STAT && pwdata[`CADC_STAT_NEW]) begin
         new_q <= 1'b0;
      end
   end

   assign link.integrate_toggle = tog_q;
   assign link.zero_input_strobe = stb_q;
   assign link.shift_clock = sck_q;
   assign link.chain_in = 1'b0;
   assign link.reset_n = rstn_q;
   assign link.sysclk_div_sel = ctrl_q[`CADC_CTRL_DIV];
   assign link.speed_power_sel = ctrl_q[`CADC_CTRL_SPD];
endmodule

// [testbench/cadc_chk.sv]
/*
 Concurrent checks on the link pins between converter and host controller.
 Assumes one sys_clk domain whose host reset is rst_n; reset_n is the link reset.
*/
`timescale 1ns/1ps
module cadc_chk #(
   parameter int RST_CYC = 20
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic integrate_toggle,
   input wire logic zero_input_strobe,
   input wire logic shift_clock,
   input wire logic chain_in,
   input wire logic chain_out,
   input wire logic result_ready_n,
   input wire logic reset_n,
   input wire logic sysclk_div_sel,
   input wire logic speed_power_sel
);
   localparam int T_LO = 1380;
   localparam int T_HI = 1388;
   localparam int D_LO = 5518;
   localparam int D_HI = 5536;
   logic [15:0] tog_q;
   logic [15:0] gap_q;
   logic [15:0] hi_q;
   logic [15:0] low_q;
   logic seen_q;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   // Cycles since the last toggle change, and the length of the period before it.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         tog_q <= 16'h0000;
         gap_q <= 16'h0000;
      end else if ($changed(integrate_toggle)) begin
         tog_q <= 16'h0001;
         gap_q <= tog_q;
      end else if (tog_q != 16'hFFFF) begin
         tog_q <= tog_q + 16'h0001;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         hi_q <= 16'h0000;
         low_q <= 16'h0000;
      end else begin
         hi_q <= zero_input_strobe ? hi_q + 16'h0001 : 16'h0000;
         low_q <= reset_n ? 16'h0000 : low_q + 16'h0001;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         seen_q <= 1'b0;
      end else if (!result_ready_n && shift_clock) begin
         seen_q <= 1'b1;
      end else if (result_ready_n) begin
         seen_q <= 1'b0;
      end
   end
   chk_ready_in_reset: assert property (!reset_n |-> result_ready_n && !chain_out)
      else $error("ready or chain output active in reset");
   chk_ready_after_rst: assert property ($rose(reset_n) |-> (result_ready_n && !chain_out)[*8])
      else $error("ready or chain output active after reset");
   chk_ready_hold_low: assert property ($rose(result_ready_n) && reset_n |-> seen_q && !shift_clock)
      else $error("ready released without a shift clock pulse");
   // A gap above one busy time means the toggle found the converter idle.
   chk_ready_delay: assert property ($fell(result_ready_n) && !sysclk_div_sel && gap_q > 16'd1475
      |-> tog_q >= T_LO && tog_q <= T_HI)
      else $error("continuous ready delay off");
   chk_ready_div_delay: assert property ($fell(result_ready_n) && sysclk_div_sel && gap_q > 16'd5885
      |-> tog_q >= D_LO && tog_q <= D_HI)
      else $error("divided ready delay off");
   chk_shift_idle_tog: assert property ($changed(integrate_toggle) |-> !shift_clock && !$past(shift_clock))
      else $error("shift clock high at a toggle change");
   chk_strobe_high_min: assert property ($fell(zero_input_strobe) |-> hi_q >= 16'd100)
      else $error("strobe high phase too short");
   chk_strobe_across: assert property ($changed(integrate_toggle) && zero_input_strobe
      |-> $past(zero_input_strobe) && $past(zero_input_strobe, 2))
      else $error("strobe not held across toggle change");
   chk_reset_width: assert property ($rose(reset_n) |-> low_q >= RST_CYC - 1)
      else $error("link reset pulse too short");
   cover property ($fell(result_ready_n) && !sysclk_div_sel);
   cover property ($fell(result_ready_n) && sysclk_div_sel);
   cover property ($rose(zero_input_strobe) && speed_power_sel);
   cover property ($rose(reset_n) && !chain_in);
endmodule

// [testbench/tb_current_adc_control_interface.sv]
/*
 Testbench joining host controller and converter through the link interface.
 Assumes an APB master role for the bench and constant lane samples.
*/
`timescale 1ns/1ps
module tb_current_adc_control_interface;
   localparam int RST = 20;
   localparam int LIMIT = 95000;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [159:0] lane_sample;
   logic test_active;
   logic cont_mode;
   logic hi_speed;
   logic tog_prev = 1'b0;
   int n_mismatch = 0;
   int checks_done = 0;
   int cyc = 0;
   int tcount = 0;
   int t0 = 0;
   initial forever #5 sys_clk = ~sys_clk;
   cadc_if link_if ();
   cadc_device u_cadc_device (.sys_clk(sys_clk), .link(link_if.dev), .lane_sample(lane_sample),
      .test_active(test_active), .cont_mode(cont_mode), .hi_speed(hi_speed));
   cadc_host #(.RST_CYC(RST), .TST_LO(4)) u_cadc_host (.sys_clk(sys_clk), .rst_n(rst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link_if.host));
   cadc_chk #(.RST_CYC(RST)) u_cadc_chk (.sys_clk(sys_clk), .rst_n(rst_n),
      .integrate_toggle(link_if.integrate_toggle), .zero_input_strobe(link_if.zero_input_strobe),
      .shift_clock(link_if.shift_clock), .chain_in(link_if.chain_in),
      .chain_out(link_if.chain_out), .result_ready_n(link_if.result_ready_n),
      .reset_n(link_if.reset_n), .sysclk_div_sel(link_if.sysclk_div_sel),
      .speed_power_sel(link_if.speed_power_sel));
   task automatic wrap_up();
      $display("mismatches %0d, comparisons %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_e);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      if (!exp_e) chk("prdata", exp, r);
      chk("pslverr", {31'h0, exp_e}, {31'h0, e});
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic exp_e);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
      chk("pslverr", {31'h0, exp_e}, {31'h0, e});
   endtask
   // Polls the new-data flag and clears it; the global cycle limit bounds the wait.
   task automatic next_result();
      logic [31:0] r;
      logic e;
      r = 32'h0;
      while (r[0] !== 1'b1) apb(1'b0, 12'h00C, 32'h0, r, e);
      wr(12'h00C, 32'h1, 1'b0);
   endtask
   // Compares the resetting and discarding status bits only.
   task automatic stat_bits(input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, 12'h00C, 32'h0, r, e);
      chk("status", exp, r & 32'h00000006);
   endtask
   task automatic data_all(input logic lanes, input logic [19:0] v);
      for (int i = 0; i < 8; i++) begin
         rd(12'h010 + 12'(4 * i), {12'h0, lanes ? lane_sample[i*20+:20] : v}, 1'b0);
      end
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (link_if.integrate_toggle !== tog_prev) tcount++;
      tog_prev = link_if.integrate_toggle;
      if (cyc == LIMIT) begin
         n_mismatch++;
         wrap_up();
      end
   end
   initial begin
      for (int i = 0; i < 8; i++) lane_sample[i*20+:20] = 20'h00A05 + 20'(i) * 20'h11111;
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd(12'h004, 32'h00009C40, 1'b0);
      rd(12'h000, 32'h0, 1'b0);
      rd(12'h100, 32'h0, 1'b1);
      rd(12'h002, 32'h0, 1'b1);
      wr(12'h010, 32'h1, 1'b1);
      wr(12'h004, 32'h00001194, 1'b0);
      rd(12'h004, 32'h00001194, 1'b0);
      wr(12'h008, 32'h3, 1'b0);
      rd(12'h008, 32'h3, 1'b0);
      wr(12'h000, 32'h1, 1'b0);
      next_result();
      chk("periods before data", 32'h1, {31'h0, tcount >= 5});
      chk("cont_mode", 32'h1, {31'h0, cont_mode});
      data_all(1'b1, 20'h0);
      wr(12'h000, 32'hB, 1'b0);
      next_result();
      next_result();
      chk("test_active", 32'h1, {31'h0, test_active});
      chk("hi_speed", 32'h1, {31'h0, hi_speed});
      data_all(1'b0, 20'h21000);
      t0 = tcount;
      wr(12'h000, 32'h1, 1'b0);
      next_result();
      chk("periods after test", 32'h1, {31'h0, (tcount - t0) >= 5});
      chk("test_active", 32'h0, {31'h0, test_active});
      chk("hi_speed", 32'h0, {31'h0, hi_speed});
      data_all(1'b1, 20'h0);
      wr(12'h004, 32'h00002328, 1'b0);
      wr(12'h000, 32'h5, 1'b0);
      next_result();
      next_result();
      data_all(1'b1, 20'h0);
      wr(12'h000, 32'h0, 1'b0);
      wr(12'h004, 32'h000003E8, 1'b0);
      wr(12'h000, 32'h1, 1'b0);
      repeat (3000) @(posedge sys_clk);
      chk("cont_mode", 32'h0, {31'h0, cont_mode});
      wr(12'h000, 32'h10, 1'b0);
      stat_bits(32'h00000006);
      repeat (30) @(posedge sys_clk);
      stat_bits(32'h00000004);
      wrap_up();
   end
endmodule
